//--- rtl/pci_bridge_pkg.sv
package pci_bridge_pkg;
  localparam int BURST_LEN      = 4;
  localparam int NUM_FUNCS      = 3;
  localparam int IO_SPACE_BITS  = 6;
  localparam logic [3:0] CMD_IO_RD  = 4'h2;
  localparam logic [3:0] CMD_IO_WR  = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [7:0] CFG_ID_OFS    = 8'h00;
  localparam logic [7:0] CFG_CMD_OFS   = 8'h04;
  localparam logic [7:0] CFG_BAR_OFS   = 8'h10;
  localparam logic [7:0] CFG_MWAIT_OFS = 8'h40;
  localparam int CMD_IO_BIT     = 0;
  localparam int CMD_MASTER_BIT = 2;
  localparam logic MWAIT_RESET  = 1'b1;
  localparam logic [2:0] CFG_WAITS      = 3'h1;
  localparam logic [2:0] IO_WAITS_MIN   = 3'h2;
  localparam logic [2:0] IO_WAITS_MAX   = 3'h5;
  localparam logic [2:0] DEVSEL_TIMEOUT = 3'h6;

  typedef enum logic [2:0] {T_IDLE, T_WAIT, T_DATA, T_STOP, T_TURN} t_state_t;
  typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} m_state_t;

  typedef struct packed {
    logic                    write;
    logic [1:0]              func;
    logic [IO_SPACE_BITS-1:0] offset;
    logic [3:0]              be_n;
    logic [31:0]             data;
  } io_req_t;

  typedef struct packed {
    logic                           write;
    logic [31:0]                    addr;
    logic [BURST_LEN-1:0][31:0]     data;
  } mst_cmd_t;

  typedef struct packed {
    logic                           abort;
    logic [BURST_LEN-1:0][31:0]     rdata;
  } mst_result_t;
endpackage

//--- rtl/pci_bridge.sv
// Functional notes
// - 32-bit bus, any clock up to 33 MHz.
// - Bus behaviour follows PCI revision 2.1.
// - Per-function config registers with I/O base.
// - Master performs memory read/write bursts.
// - Master wait states 0 or 1, default 1.
// - Normal master burst moves four doublewords.
// - Config target data phase has one wait.
// - I/O target data phase has 2-5 waits.
// - Claim I/O only on command and base match.
// - Config needs select, type 0 address bits.
// - Target disconnects bursts with stop asserted.
// - Master aborts after six clocks without select.
`timescale 1ns/10ps
`default_nettype none
module pci_bridge
  import pci_bridge_pkg::*;
#(
  parameter logic [31:0] DEVICE_ID = 32'h0001_0001 // Value is arbitrary.
) (
  input  wire logic                         clk_in,
  input  wire logic                         reset_in,
  input  wire logic [31:0]                  ad_in,
  output var  logic [31:0]                  ad_out,
  output var  logic                         ad_oe_n_out,
  input  wire logic [3:0]                   cbe_in,
  output var  logic [3:0]                   cbe_out,
  output var  logic                         cbe_oe_n_out,
  input  wire logic                         frame_n_in,
  output var  logic                         frame_n_out,
  output var  logic                         frame_oe_n_out,
  input  wire logic                         irdy_n_in,
  output var  logic                         irdy_n_out,
  output var  logic                         irdy_oe_n_out,
  input  wire logic                         trdy_n_in,
  output var  logic                         trdy_n_out,
  output var  logic                         trdy_oe_n_out,
  input  wire logic                         devsel_n_in,
  output var  logic                         devsel_n_out,
  output var  logic                         devsel_oe_n_out,
  input  wire logic                         stop_n_in,
  output var  logic                         stop_n_out,
  output var  logic                         stop_oe_n_out,
  input  wire logic                         idsel_in,
  output var  logic                         req_n_out,
  input  wire logic                         gnt_n_in,
  output var  logic                         io_valid_out,
  output var  pci_bridge_pkg::io_req_t      io_req_out,
  input  wire logic                         io_ack_in,
  input  wire logic [31:0]                  io_rdata_in,
  input  wire logic                         mst_valid_in,
  input  wire pci_bridge_pkg::mst_cmd_t     mst_cmd_in,
  output var  logic                         mst_busy_out,
  output var  logic                         mst_done_out,
  output var  pci_bridge_pkg::mst_result_t  mst_result_out
);
  import pci_bridge_pkg::*;

  t_state_t       t_state;
  m_state_t       m_state;
  logic           frame_q;
  logic           t_cfg, t_write, io_sent, io_got, mwait, dsel_seen;
  logic [1:0]     t_func;
  logic [7:0]     t_addr;
  logic [2:0]     wcnt, tcnt;
  logic [1:0]     widx;
  logic [31:0]    io_rdata_q;
  mst_cmd_t       mcmd;
  logic [NUM_FUNCS-1:0] io_en, mst_en, io_match;
  logic [31:0]    bar [NUM_FUNCS];

  // The whole block is synchronous to one bus clock, so any rate up to
  // the bus maximum works without change.
  wire addr_phase = !frame_n_in && frame_q && frame_oe_n_out &&
                    t_state == T_IDLE;
  wire cfg_cmd  = cbe_in == CMD_CFG_RD || cbe_in == CMD_CFG_WR;
  wire io_cmd   = cbe_in == CMD_IO_RD || cbe_in == CMD_IO_WR;
  wire cfg_hit  = addr_phase && idsel_in && cfg_cmd &&
                  ad_in[1:0] == 2'b00 && ad_in[10:8] < 3'(NUM_FUNCS);
  wire io_hit   = addr_phase && io_cmd && |io_match;
  wire [1:0] io_func = io_match[1] ? 2'h1 : (io_match[2] ? 2'h2 : 2'h0);
  wire io_done  = io_got || io_ack_in;
  wire t_ready  = t_cfg ? wcnt >= CFG_WAITS - 3'h1 :
                  io_sent && wcnt >= IO_WAITS_MIN - 3'h1 &&
                  (io_done || wcnt >= IO_WAITS_MAX - 3'h1);
  wire t_fin    = t_state == T_WAIT && t_ready;
  wire t_xfer   = t_state == T_DATA && !irdy_n_in;
  wire cfg_wr   = t_xfer && t_cfg && t_write;
  wire [31:0] cfg_rdata =
      t_addr == CFG_ID_OFS  ? DEVICE_ID :
      t_addr == CFG_CMD_OFS ? {29'h0, mst_en[t_func], 1'b0, io_en[t_func]} :
      t_addr == CFG_BAR_OFS ? {bar[t_func][31:IO_SPACE_BITS], 6'h01} :
      t_addr == CFG_MWAIT_OFS && t_func == 2'h0 ? {31'h0, mwait} : 32'h0;
  wire m_start  = m_state == M_REQ && !gnt_n_in && frame_n_in &&
                  irdy_n_in && t_state == T_IDLE;
  wire m_xfer   = m_state == M_DATA && !irdy_n_out && !trdy_n_in &&
                  !devsel_n_in;
  wire m_last   = widx == 2'(BURST_LEN - 1) || !stop_n_in;
  wire m_tmo    = m_state == M_DATA && !dsel_seen && devsel_n_in &&
                  tcnt == DEVSEL_TIMEOUT - 3'h1;
  wire m_halt   = m_state == M_DATA && !stop_n_in && trdy_n_in &&
                  !devsel_n_in;
  wire [1:0] widx_nx = widx + 2'h1;

  // Each function keeps its own command bits and I/O base.
  genvar f;
  generate
    for (f = 0; f < NUM_FUNCS; f++) begin : g_func
      assign io_match[f] = io_en[f] &&
          ad_in[31:IO_SPACE_BITS] == bar[f][31:IO_SPACE_BITS];
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          io_en[f]  <= 1'b0;
          mst_en[f] <= 1'b0;
          bar[f]    <= 32'h0;
        end else if (cfg_wr && t_func == 2'(f)) begin
          if (t_addr == CFG_CMD_OFS && !cbe_in[0]) begin
            io_en[f]  <= ad_in[CMD_IO_BIT];
            mst_en[f] <= ad_in[CMD_MASTER_BIT];
          end
          if (t_addr == CFG_BAR_OFS) begin
            for (int b = 0; b < 4; b++) begin
              if (!cbe_in[b]) begin
                bar[f][8*b +: 8] <= ad_in[8*b +: 8];
              end
            end
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mwait <= MWAIT_RESET;
    end else if (cfg_wr && t_func == 2'h0 && t_addr == CFG_MWAIT_OFS &&
                 !cbe_in[0]) begin
      mwait <= ad_in[0];
    end
  end

  // Target side. Bursts are never taken: the first data phase ends the
  // transaction, which keeps the register decode simple.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      t_state <= T_IDLE;
      frame_q <= 1'b1;
      {t_cfg, t_write, io_sent, io_got, io_valid_out} <= 5'h0;
      {t_func, t_addr, wcnt, io_rdata_q} <= '0;
      io_req_out <= '0;
      {trdy_n_out, devsel_n_out, stop_n_out} <= 3'h7;
      {trdy_oe_n_out, devsel_oe_n_out, stop_oe_n_out} <= 3'h7;
    end else begin
      frame_q      <= frame_n_in;
      io_valid_out <= 1'b0;
      case (t_state)
        T_IDLE: begin
          {trdy_oe_n_out, devsel_oe_n_out, stop_oe_n_out} <= 3'h7;
          if (cfg_hit || io_hit) begin
            t_state <= T_WAIT;
            t_cfg   <= cfg_hit;
            t_write <= cbe_in[0];
            t_func  <= cfg_hit ? ad_in[9:8] : io_func;
            t_addr  <= ad_in[7:0];
            {wcnt, io_sent, io_got} <= 5'h0;
            devsel_n_out <= 1'b0;
            {trdy_oe_n_out, devsel_oe_n_out, stop_oe_n_out} <= 3'h0;
          end
        end
        T_WAIT: begin
          wcnt <= wcnt + 3'h1;
          if (io_sent && io_ack_in) begin
            io_got     <= 1'b1;
            io_rdata_q <= io_rdata_in;
          end
          if (!t_cfg && !io_sent && !irdy_n_in) begin
            io_sent      <= 1'b1;
            io_valid_out <= 1'b1;
            io_req_out   <= '{t_write, t_func, t_addr[IO_SPACE_BITS-1:0],
                              cbe_in, ad_in};
          end
          if (t_fin) begin
            t_state    <= T_DATA;
            trdy_n_out <= 1'b0;
            stop_n_out <= frame_n_in || irdy_n_in;
          end
        end
        T_DATA: begin
          if (t_xfer) begin
            trdy_n_out <= 1'b1;
            if (!frame_n_in) begin
              t_state    <= T_STOP;
              stop_n_out <= 1'b0;
            end else begin
              t_state <= T_TURN;
              {devsel_n_out, stop_n_out} <= 2'h3;
            end
          end
        end
        T_STOP: begin
          if (frame_n_in) begin
            t_state <= T_TURN;
            {devsel_n_out, stop_n_out} <= 2'h3;
          end
        end
        default: t_state <= T_IDLE;
      endcase
    end
  end

  // Master side: one four-word burst per command.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      m_state <= M_IDLE;
      mcmd    <= '0;
      {widx, tcnt, dsel_seen, mst_busy_out, mst_done_out} <= '0;
      mst_result_out <= '0;
      {req_n_out, frame_n_out, irdy_n_out} <= 3'h7;
      {frame_oe_n_out, irdy_oe_n_out, cbe_oe_n_out} <= 3'h7;
      cbe_out <= 4'h0;
    end else begin
      mst_done_out <= 1'b0;
      case (m_state)
        M_IDLE: begin
          if (mst_valid_in && mst_en[0]) begin
            m_state      <= M_REQ;
            mcmd         <= mst_cmd_in;
            mst_busy_out <= 1'b1;
            req_n_out    <= 1'b0;
          end
        end
        M_REQ: begin
          if (m_start) begin
            m_state     <= M_ADDR;
            req_n_out   <= 1'b1;
            frame_n_out <= 1'b0;
            cbe_out     <= mcmd.write ? CMD_MEM_WR : CMD_MEM_RD;
            {frame_oe_n_out, cbe_oe_n_out} <= 2'h0;
          end
        end
        M_ADDR: begin
          m_state       <= M_DATA;
          irdy_oe_n_out <= 1'b0;
          irdy_n_out    <= mwait;
          cbe_out       <= 4'h0;
          {widx, tcnt, dsel_seen} <= '0;
          mst_result_out.abort <= 1'b0;
        end
        M_DATA: begin
          tcnt <= tcnt + 3'h1;
          if (!devsel_n_in) begin
            dsel_seen <= 1'b1;
          end
          if (m_xfer) begin
            mst_result_out.rdata[widx] <= ad_in;
            if (m_last) begin
              m_state <= M_TURN;
              {frame_n_out, irdy_n_out} <= 2'h3;
              mst_result_out.abort <= widx != 2'(BURST_LEN - 1);
            end else begin
              widx        <= widx_nx;
              irdy_n_out  <= mwait;
              frame_n_out <= !mwait && widx_nx == 2'(BURST_LEN - 1);
            end
          end else if (m_tmo || m_halt) begin
            m_state <= M_TURN;
            {frame_n_out, irdy_n_out} <= 2'h3;
            mst_result_out.abort <= 1'b1;
          end else if (irdy_n_out) begin
            irdy_n_out  <= 1'b0;
            frame_n_out <= widx == 2'(BURST_LEN - 1);
          end
        end
        default: begin
          m_state      <= M_IDLE;
          mst_busy_out <= 1'b0;
          mst_done_out <= 1'b1;
          {frame_oe_n_out, irdy_oe_n_out, cbe_oe_n_out} <= 3'h7;
        end
      endcase
    end
  end

  // Address/data lines: shared by both sides, so one process owns them.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ad_out      <= 32'h0;
      ad_oe_n_out <= 1'b1;
    end else if (m_start) begin
      ad_out      <= mcmd.addr;
      ad_oe_n_out <= 1'b0;
    end else if (m_state == M_ADDR) begin
      ad_out      <= mcmd.data[0];
      ad_oe_n_out <= !mcmd.write;
    end else if (m_xfer && !m_last) begin
      ad_out <= mcmd.data[widx_nx];
    end else if (m_state == M_TURN || t_state == T_TURN) begin
      ad_oe_n_out <= 1'b1;
    end else if (t_fin && !t_write) begin
      ad_out      <= t_cfg ? cfg_rdata : (io_got ? io_rdata_q : io_rdata_in);
      ad_oe_n_out <= 1'b0;
    end else if (t_xfer) begin
      ad_oe_n_out <= 1'b1;
    end
  end

  logic [2:0] xfer_cnt;
  always_ff @(posedge clk_in) begin
    if (reset_in || m_state == M_ADDR) begin
      xfer_cnt <= 3'h0;
    end else if (m_xfer) begin
      xfer_cnt <= xfer_cnt + 3'h1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_cfg_one_wait: assert property (cfg_hit |=>
      trdy_n_out ##1 !trdy_n_out) else $error("config wait not one");
  a_io_wait_span: assert property (io_hit ##1 !irdy_n_in |->
      trdy_n_out ##1 trdy_n_out ##[1:4] !trdy_n_out)
      else $error("io waits out of range");
  a_io_claim_cmd: assert property (
      $rose(t_state == T_WAIT) && !t_cfg |->
      $past(cbe_in) == CMD_IO_RD || $past(cbe_in) == CMD_IO_WR)
      else $error("io claimed on wrong command");
  a_devsel_hold: assert property (
      t_state inside {T_WAIT, T_DATA, T_STOP} |->
      !devsel_n_out && !devsel_oe_n_out) else $error("devsel dropped");
  a_cfg_type0: assert property ($rose(t_state == T_WAIT) && t_cfg |->
      $past(idsel_in) && $past(ad_in[1:0]) == 2'b00)
      else $error("config claimed without select");
  a_burst_stop: assert property ($fell(trdy_n_out) &&
      $past(!frame_n_in && !irdy_n_in) |-> !stop_n_out && !devsel_n_out)
      else $error("burst not disconnected");
  a_mst_abort_six: assert property (m_state == M_ADDR ##1
      (devsel_n_in && stop_n_in)[*6] |=> m_state == M_TURN &&
      mst_result_out.abort) else $error("master abort timing");
  a_burst_four: assert property (mst_done_out && !mst_result_out.abort
      |-> xfer_cnt == 3'h4) else $error("burst not four words");
  a_wait_one: assert property (m_state == M_ADDR && mwait |=>
      irdy_n_out ##1 !irdy_n_out) else $error("missing master wait");
  a_wait_zero: assert property (m_state == M_ADDR && !mwait |=>
      !irdy_n_out) else $error("unexpected master wait");

  c_cfg_access: cover property (t_xfer && t_cfg);
  c_io_access: cover property (t_xfer && !t_cfg);
  c_burst_done: cover property (mst_done_out && !mst_result_out.abort);
  c_mst_abort: cover property (m_tmo);
endmodule
`default_nettype wire

//--- bench/pci_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Memory target for the bridge's bursts. It never claims config or I/O,
// and a slow answer stretches every data phase after the first by one wait.
module pci_mem_model (
  input  wire logic        clk_in,
  input  wire logic        answer_in,
  input  wire logic        slow_in,
  input  wire logic        frame_n_in,
  input  wire logic        irdy_n_in,
  input  wire logic [3:0]  cbe_in,
  input  wire logic [31:0] ad_in,
  output var  logic        devsel_n_out,
  output var  logic        trdy_n_out,
  output var  logic        ad_oe_n_out,
  output var  logic [31:0] ad_out
);
  logic [31:0] mem [4];
  logic        frame_d = 1'b1;
  logic        active = 1'b0;
  logic        wr = 1'b0;
  logic [1:0]  idx = 2'h0;
  wire         xfer = active && !trdy_n_out && !irdy_n_in;

  initial begin
    devsel_n_out = 1'b1;
    trdy_n_out = 1'b1;
  end
  assign ad_out = mem[idx];
  assign ad_oe_n_out = !(active && !wr && !devsel_n_out);
  always @(posedge clk_in) begin
    frame_d <= frame_n_in;
    if (frame_d && !frame_n_in && answer_in && cbe_in[3:1] == 3'h3) begin
      active <= 1'b1;
      wr <= cbe_in[0];
      idx <= 2'h0;
      devsel_n_out <= 1'b0;
      trdy_n_out <= 1'b1;
    end else if (active) begin
      if (xfer && wr) mem[idx] <= ad_in;
      if (xfer) idx <= idx + 2'h1;
      if (xfer && frame_n_in) begin
        active <= 1'b0;
        devsel_n_out <= 1'b1;
        trdy_n_out <= 1'b1;
      end else begin
        trdy_n_out <= slow_in ? !trdy_n_out : 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/pci_bridge_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pci_bridge_bench;
  import pci_bridge_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        idsel_in = 1'b0;
  logic        io_ack_in = 1'b0;
  logic        ack_en = 1'b1;
  logic        gnt_n_in = 1'b1;
  logic        mst_valid_in = 1'b0;
  logic        h_frame = 1'b1;
  logic        h_irdy = 1'b1;
  logic        h_ad_on = 1'b0;
  logic        answer = 1'b1;
  logic        slow = 1'b0;
  logic        mon = 1'b0;
  logic        last_frame = 1'b0;
  logic        cl, st;
  logic [3:0]  h_cbe = 4'h0;
  logic [3:0]  d_cbe;
  logic [31:0] h_ad = 32'h0;
  logic [31:0] ad_last = 32'h0;
  logic [31:0] d_ad, m_ad, r;
  logic        d_ad_oe, d_cbe_oe, d_frame, d_frame_oe, d_irdy, d_irdy_oe;
  logic        d_trdy, d_trdy_oe, d_devsel, d_devsel_oe, d_stop, d_stop_oe;
  logic        req_n_out, io_valid_out, mst_busy_out, mst_done_out;
  logic        m_devsel, m_trdy, m_ad_oe;
  io_req_t     io_req_out, io_seen;
  mst_cmd_t    mst_cmd_in = '0;
  mst_result_t mst_result_out;
  int          fails = 0;
  int          n_tests = 0;
  int          xfers, gaps, wt;
  // Released lines: controls float high, AD shows a changing pattern.
  wire [31:0]  ad_w = !d_ad_oe ? d_ad : !m_ad_oe ? m_ad :
                      h_ad_on ? h_ad : ~ad_last;
  wire [3:0]   cbe_w = d_cbe_oe ? h_cbe : d_cbe;
  wire         frame_w = d_frame_oe ? h_frame : d_frame;
  wire         irdy_w = d_irdy_oe ? h_irdy : d_irdy;
  wire         trdy_w = d_trdy_oe ? m_trdy : d_trdy;
  wire         devsel_w = d_devsel_oe ? m_devsel : d_devsel;
  wire         stop_w = d_stop_oe | d_stop;

  pci_bridge #(.DEVICE_ID(32'h0000_5a5a)) i_pci_bridge (
    .clk_in(clk_in), .reset_in(reset_in), .ad_in(ad_w), .ad_out(d_ad),
    .ad_oe_n_out(d_ad_oe), .cbe_in(cbe_w), .cbe_out(d_cbe),
    .cbe_oe_n_out(d_cbe_oe), .frame_n_in(frame_w), .frame_n_out(d_frame),
    .frame_oe_n_out(d_frame_oe), .irdy_n_in(irdy_w), .irdy_n_out(d_irdy),
    .irdy_oe_n_out(d_irdy_oe), .trdy_n_in(trdy_w), .trdy_n_out(d_trdy),
    .trdy_oe_n_out(d_trdy_oe), .devsel_n_in(devsel_w),
    .devsel_n_out(d_devsel), .devsel_oe_n_out(d_devsel_oe),
    .stop_n_in(stop_w), .stop_n_out(d_stop), .stop_oe_n_out(d_stop_oe),
    .idsel_in(idsel_in), .req_n_out(req_n_out), .gnt_n_in(gnt_n_in),
    .io_valid_out(io_valid_out), .io_req_out(io_req_out),
    .io_ack_in(io_ack_in), .io_rdata_in(32'h0bad_f00d),
    .mst_valid_in(mst_valid_in), .mst_cmd_in(mst_cmd_in),
    .mst_busy_out(mst_busy_out), .mst_done_out(mst_done_out),
    .mst_result_out(mst_result_out));
  pci_mem_model i_pci_mem_model (
    .clk_in(clk_in), .answer_in(answer), .slow_in(slow),
    .frame_n_in(frame_w), .irdy_n_in(irdy_w), .cbe_in(cbe_w), .ad_in(ad_w),
    .devsel_n_out(m_devsel), .trdy_n_out(m_trdy), .ad_oe_n_out(m_ad_oe),
    .ad_out(m_ad));

  initial begin
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) ad_last <= ad_w;
  always @(negedge clk_in) begin
    gnt_n_in <= req_n_out;
    io_ack_in <= io_valid_out && ack_en;
    if (io_valid_out) io_seen <= io_req_out;
  end
  always @(posedge clk_in) begin
    if (mon && !irdy_w && !trdy_w) begin
      xfers++;
      last_frame = frame_w;
    end
    if (mon && !devsel_w && irdy_w) gaps++;
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single-phase host cycle; brst keeps the frame low into the data phase.
  task automatic bus(input logic [3:0] cmd, input logic [31:0] a, w,
                     input logic sel, brst);
    wt = 0;
    cl = 1'b0;
    @(negedge clk_in);
    h_frame = 1'b0;
    h_ad_on = 1'b1;
    h_ad = a;
    h_cbe = cmd;
    idsel_in = sel;
    @(negedge clk_in);
    h_frame = !brst;
    h_irdy = 1'b0;
    h_cbe = 4'h0;
    idsel_in = 1'b0;
    h_ad_on = cmd[0];
    h_ad = w;
    // A cycle that nobody claims is given up after five clocks.
    while (wt < 9 && trdy_w !== 1'b0 && (cl || wt < 5)) begin
      cl = cl | !devsel_w;
      wt++;
      @(negedge clk_in);
    end
    if (wt >= 9) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, wt, 5);
      print_verdict();
    end
    cl = cl | !devsel_w;
    r = ad_w;
    st = stop_w;
    @(negedge clk_in);
    h_frame = 1'b1;
    h_irdy = 1'b1;
    h_ad_on = 1'b0;
    @(negedge clk_in);
  endtask

  task automatic t_reset();
    chk(&{d_ad_oe, d_cbe_oe, d_frame_oe, d_irdy_oe, d_trdy_oe, d_devsel_oe,
          d_stop_oe, req_n_out}, 32'h1);
    bus(CMD_CFG_RD, {24'h0, CFG_MWAIT_OFS}, 32'h0, 1'b1, 1'b0);
    chk(r & 32'h1, 32'h1);
  endtask

  task automatic t_config();
    bus(CMD_CFG_WR, {24'h0, CFG_CMD_OFS}, 32'h5, 1'b1, 1'b0);
    chk(wt, 32'h1);
    bus(CMD_CFG_WR, 32'h104, 32'h1, 1'b1, 1'b0);
    bus(CMD_CFG_WR, 32'h110, 32'h1040, 1'b1, 1'b0);
    bus(CMD_CFG_RD, 32'h110, 32'h0, 1'b1, 1'b0);
    chk(r, 32'h1041);
    chk(wt, 32'h1);
    bus(CMD_CFG_RD, 32'h110, 32'h0, 1'b0, 1'b0);
    chk(cl, 32'h0);
    bus(CMD_CFG_RD, 32'h111, 32'h0, 1'b1, 1'b0);
    chk(cl, 32'h0);
  endtask

  task automatic t_io();
    bus(CMD_IO_WR, 32'h1048, 32'h1234_5678, 1'b0, 1'b0);
    chk(32'(wt >= 2 && wt <= 5 && cl), 32'h1);
    chk({io_seen.write, io_seen.func, io_seen.offset, io_seen.be_n},
        32'h1480);
    chk(io_seen.data, 32'h1234_5678);
    bus(CMD_IO_RD, 32'h104c, 32'h0, 1'b0, 1'b0);
    chk(r, 32'h0bad_f00d);
    ack_en = 1'b0;
    bus(CMD_IO_RD, 32'h104c, 32'h0, 1'b0, 1'b0);
    chk(wt, 32'h5);
    ack_en = 1'b1;
    bus(CMD_IO_RD, 32'h1088, 32'h0, 1'b0, 1'b0);
    chk(cl, 32'h0);
    answer = 1'b0;
    bus(CMD_MEM_RD, 32'h1048, 32'h0, 1'b0, 1'b0);
    chk(cl, 32'h0);
    answer = 1'b1;
  endtask

  task automatic t_burst();
    bus(CMD_CFG_RD, {24'h0, CFG_ID_OFS}, 32'h0, 1'b1, 1'b1);
    chk(st, 32'h0);
    chk(r, 32'h0000_5a5a);
  endtask

  // A negative gap count means the wait pattern is not judged.
  task automatic t_master(input logic wr, input int exp_gap);
    int i;
    xfers = 0;
    gaps = 0;
    @(negedge clk_in);
    mon = 1'b1;
    mst_cmd_in = {wr, 32'h0000_2000, 32'h4444_0004, 32'h3333_0003,
                  32'h2222_0002, 32'h1111_0001};
    mst_valid_in = 1'b1;
    for (i = 0; i < 80; i++) begin
      @(negedge clk_in);
      if (mst_busy_out) mst_valid_in = 1'b0;
      if (mst_done_out) break;
    end
    mon = 1'b0;
    chk(32'(i < 80), 32'h1);
    if (i >= 80) print_verdict();
    chk(mst_result_out.abort, 32'(!answer));
    if (!answer) chk(32'(i < 16), 32'h1);
    if (answer) begin
      chk(xfers, 32'h4);
      chk(last_frame, 32'h1);
      if (exp_gap >= 0) chk(gaps, exp_gap);
      for (int k = 0; k < 4; k++) begin
        chk(wr ? i_pci_mem_model.mem[k] : mst_result_out.rdata[k],
            32'h1111_0001 * (k + 1));
      end
    end
  endtask

  initial begin
    repeat (20) @(negedge clk_in);
    reset_in = 1'b0;
    t_reset();
    t_config();
    t_io();
    t_burst();
    t_master(1'b1, 4);
    bus(CMD_CFG_WR, {24'h0, CFG_MWAIT_OFS}, 32'h0, 1'b1, 1'b0);
    t_master(1'b0, 0);
    slow = 1'b1;
    t_master(1'b0, -1);
    slow = 1'b0;
    answer = 1'b0;
    t_master(1'b1, -1);
    answer = 1'b1;
    // A second reset must bring back the defaults and drop the I/O decode.
    reset_in = 1'b1;
    repeat (3) @(negedge clk_in);
    reset_in = 1'b0;
    t_reset();
    bus(CMD_IO_RD, 32'h104c, 32'h0, 1'b0, 1'b0);
    chk(cl, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
